// ### design/dpms_pkg.sv
// Package: constants, types and pin bundles for the dual-port mailbox/semaphore host
`default_nettype none
package dpms_pkg;
    // ==========================================================
    // Widths and clock
    localparam int ADDR_W       = 16;
    localparam int DATA_W       = 18;
    localparam int TOKEN_ADDR_W = 3;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYNC_STAGES   = 2;

    // ==========================================================
    // Mailbox words of the 64K variant (32K variant: 7fff / 7ffe)
    localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR   = 16'hffff;
    localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR    = 16'hfffe;
    localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR_S = 16'h7fff;
    localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR_S  = 16'h7ffe;

    // ==========================================================
    // Times in ns; plain defaults for the slowest speed grade
    localparam int SELECT_ACCESS_NS      = 25;
    localparam int OE_ACCESS_NS          = 13;
    localparam int FLAG_SETTLE_NS        = 25;
    localparam int WRITE_PULSE_NS        = 22;
    localparam int TOKEN_RECOVERY_NS     = 15;
    localparam int TOKEN_WRITE_READ_NS   = 15;

    // Cycle counts, least times rounded up; access also adds the synchroniser stages
    localparam logic [7:0] SETTLE_CYC =
        8'((FLAG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACCESS_CYC =
        8'((SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
    localparam logic [7:0] WRITE_CYC =
        8'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] GAP_CYC =
        8'((TOKEN_RECOVERY_NS + TOKEN_WRITE_READ_NS + OE_ACCESS_NS
            + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Commands and states
    typedef enum logic [2:0] {
        OP_READ       = 3'h0,
        OP_WRITE      = 3'h1,
        OP_TOKEN_READ = 3'h2,
        OP_TOKEN_WRITE = 3'h3,
        OP_TOKEN_TAKE = 3'h4
    } dpms_op_type;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_ACCESS = 3'b011,
        ST_GAP    = 3'b010,
        ST_DONE   = 3'b110
    } dpms_state_type;

    typedef struct packed {
        dpms_op_type         op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } dpms_cmd_type;

    typedef struct packed {
        logic                port_select_n;
        logic                token_latch_select_n;
        logic                output_drive_enable_n;
        logic                read_write_n;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_o;
        logic                dq_oe;
    } dpms_pins_type;

    localparam dpms_pins_type PINS_IDLE = '{
        port_select_n: 1'b1, token_latch_select_n: 1'b1,
        output_drive_enable_n: 1'b1, read_write_n: 1'b1,
        addr: '0, dq_o: '0, dq_oe: 1'b0};
endpackage : dpms_pkg
`default_nettype wire

// ### design/dpms_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`default_nettype none
module dpms_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] rst_val,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d    = meta_q;
    end

    // Reset loads zero; rst_val is a constant tied at the instance and XORed into q, never a live signal
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= meta_d;
            q      <= q_d ^ rst_val;
        end
    end
endmodule : dpms_sync
`default_nettype wire

// ### design/dpms_host.sv
// One-port host controller for the dual-port memory: array, mailbox and token cycles
//
// Functional notes
// - Array read: drive select and output enable
// - Token read: token select replaces port select
// - No slave write before busy settles
// - Token access: port select high, bits 0-2
// - Request token: write zero, read back
// - Recovery gap before token read-back
// - Write one to withdraw token claim
`default_nettype none
module dpms_host (
    input  wire logic                          ref_clk,
    input  wire logic                          arst_n,
    // User command side
    input  wire logic                          cmd_valid,
    input  wire dpms_pkg::dpms_cmd_type        cmd,
    output var  logic                          cmd_ready,
    output var  logic                          rsp_valid,
    output var  logic [dpms_pkg::DATA_W-1:0]   rsp_data,
    output var  logic                          rsp_busy_seen,
    output var  logic                          msg_pending,
    output var  logic                          busy_active,
    // Memory port pins
    output var  dpms_pkg::dpms_pins_type       pins,
    input  wire logic [dpms_pkg::DATA_W-1:0]   dq_i,
    input  wire logic                          busy_n_i,
    input  wire logic                          message_flag_n_i
);
    // ==========================================================
    // Pin synchronisers
    logic [dpms_pkg::DATA_W-1:0] dq_s;
    logic [1:0]                  flag_s;

    dpms_sync #(.WIDTH(dpms_pkg::DATA_W)) u_dq_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .rst_val ({dpms_pkg::DATA_W{1'b0}}),
        .d       (dq_i),
        .q       (dq_s)
    );

    // Flags are active low; invert so reset shows them inactive
    dpms_sync #(.WIDTH(2)) u_flag_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .rst_val (2'h0),
        .d       ({~busy_n_i, ~message_flag_n_i}),
        .q       (flag_s)
    );

    // ==========================================================
    // Sequencer state
    dpms_pkg::dpms_state_type state_q, state_d;
    dpms_pkg::dpms_cmd_type   cmd_q, cmd_d;
    dpms_pkg::dpms_pins_type  pins_d;
    logic [7:0]               cnt_q, cnt_d;
    logic                     wr_q, wr_d;
    logic                     token_op;
    logic                     take_op;
    logic                     token_nx;
    logic                     ready_d;
    logic                     rsp_valid_d;
    logic [dpms_pkg::DATA_W-1:0] rsp_data_d;
    logic                     busy_seen_d;

    assign token_op = (cmd_q.op == dpms_pkg::OP_TOKEN_READ)
                   || (cmd_q.op == dpms_pkg::OP_TOKEN_WRITE)
                   || (cmd_q.op == dpms_pkg::OP_TOKEN_TAKE);
    assign take_op  = (cmd_q.op == dpms_pkg::OP_TOKEN_TAKE);
    // Pins are built from the next command, so the accept cycle needs the new kind
    assign token_nx = (cmd_d.op == dpms_pkg::OP_TOKEN_READ)
                   || (cmd_d.op == dpms_pkg::OP_TOKEN_WRITE)
                   || (cmd_d.op == dpms_pkg::OP_TOKEN_TAKE);

    always_comb begin
        state_d     = state_q;
        cmd_d       = cmd_q;
        cnt_d       = cnt_q;
        wr_d        = wr_q;
        ready_d     = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d  = rsp_data;
        busy_seen_d = rsp_busy_seen;
        case (state_q)
            dpms_pkg::ST_IDLE: begin
                ready_d = 1'b1;
                if (cmd_valid && cmd_ready) begin
                    cmd_d       = cmd;
                    wr_d        = (cmd.op == dpms_pkg::OP_WRITE)
                               || (cmd.op == dpms_pkg::OP_TOKEN_WRITE)
                               || (cmd.op == dpms_pkg::OP_TOKEN_TAKE);
                    // A take starts by writing zero as its claim
                    if (cmd.op == dpms_pkg::OP_TOKEN_TAKE) begin
                        cmd_d.wdata = '0;
                    end
                    busy_seen_d = 1'b0;
                    cnt_d       = dpms_pkg::SETTLE_CYC;
                    ready_d     = 1'b0;
                    state_d     = dpms_pkg::ST_SETUP;
                end
            end
            dpms_pkg::ST_SETUP: begin
                if (flag_s[1] && !token_op) begin
                    busy_seen_d = 1'b1;
                end
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (wr_q && !token_op && flag_s[1]) begin
                    // Hold the strobe back while this port lost arbitration
                    state_d = dpms_pkg::ST_SETUP;
                end else begin
                    cnt_d   = wr_q ? dpms_pkg::WRITE_CYC : dpms_pkg::ACCESS_CYC;
                    state_d = dpms_pkg::ST_ACCESS;
                end
            end
            dpms_pkg::ST_ACCESS: begin
                if (flag_s[1] && !token_op) begin
                    busy_seen_d = 1'b1;
                end
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    if (!wr_q) begin
                        rsp_data_d = dq_s;
                    end
                    cnt_d   = dpms_pkg::GAP_CYC;
                    state_d = dpms_pkg::ST_GAP;
                end
            end
            dpms_pkg::ST_GAP: begin
                // Selects stay high so the token read-back sees a fresh cycle
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (take_op && (wr_q || rsp_data[0])) begin
                    // After the claim, keep reading until zero comes back
                    wr_d    = 1'b0;
                    cnt_d   = dpms_pkg::SETTLE_CYC;
                    state_d = dpms_pkg::ST_SETUP;
                end else begin
                    state_d = dpms_pkg::ST_DONE;
                end
            end
            dpms_pkg::ST_DONE: begin
                rsp_valid_d = 1'b1;
                ready_d     = 1'b1;
                state_d     = dpms_pkg::ST_IDLE;
            end
            default: begin
                state_d = dpms_pkg::ST_IDLE;
                ready_d = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Pin levels follow the next state so they are registered in step
    always_comb begin
        pins_d = dpms_pkg::PINS_IDLE;
        if ((state_d == dpms_pkg::ST_SETUP) || (state_d == dpms_pkg::ST_ACCESS)) begin
            if (token_nx) begin
                // Only the latch index goes out; port select stays high
                pins_d.token_latch_select_n = 1'b0;
                pins_d.addr = {{(dpms_pkg::ADDR_W - dpms_pkg::TOKEN_ADDR_W){1'b0}},
                               cmd_d.addr[dpms_pkg::TOKEN_ADDR_W-1:0]};
            end else begin
                pins_d.port_select_n = 1'b0;
                pins_d.addr          = cmd_d.addr;
            end
            if (wr_d) begin
                // Token writes carry the claim on bit zero; a one withdraws it
                pins_d.dq_o  = cmd_d.wdata;
                pins_d.dq_oe = 1'b1;
                pins_d.read_write_n = (state_d == dpms_pkg::ST_ACCESS) ? 1'b0 : 1'b1;
            end else begin
                pins_d.output_drive_enable_n = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q       <= dpms_pkg::ST_IDLE;
            cmd_q         <= '0;
            cnt_q         <= 8'h00;
            wr_q          <= 1'b0;
            pins          <= dpms_pkg::PINS_IDLE;
            cmd_ready     <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_data      <= '0;
            rsp_busy_seen <= 1'b0;
            msg_pending   <= 1'b0;
            busy_active   <= 1'b0;
        end else begin
            state_q       <= state_d;
            cmd_q         <= cmd_d;
            cnt_q         <= cnt_d;
            wr_q          <= wr_d;
            pins          <= pins_d;
            cmd_ready     <= ready_d;
            rsp_valid     <= rsp_valid_d;
            rsp_data      <= rsp_data_d;
            rsp_busy_seen <= busy_seen_d;
            msg_pending   <= flag_s[0];
            busy_active   <= flag_s[1];
        end
    end
endmodule : dpms_host
`default_nettype wire

// ### bench/dpms_dev_model.sv
// Behavioural model of the dual-port memory seen from the left port
`default_nettype none
module dpms_dev_model (
    input  wire logic                        ref_clk,
    input  wire dpms_pkg::dpms_pins_type     pins,
    input  wire logic                        busy,
    input  wire logic                        peer_msg,
    input  wire logic                        peer_tok,
    input  wire logic [2:0]                  peer_idx,
    input  wire logic                        peer_val,
    output var  logic [dpms_pkg::DATA_W-1:0] dq_i,
    output var  logic                        busy_n_i,
    output var  logic                        message_flag_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Array, latches and the latched read value
    logic [17:0] mem [logic [15:0]];
    logic [1:0]  own [8] = '{default: 2'h0};
    logic [1:0]  pend [8] = '{default: 2'h0};
    logic        flag = 1'b0;
    logic        peer_flag = 1'b0;
    logic        rd_q = 1'b0;
    logic [17:0] rval = 18'h0;
    logic [17:0] last = 18'h0;
    wire logic   rd = !pins.output_drive_enable_n
                      && (!pins.port_select_n || !pins.token_latch_select_n);

    // Side 1 is this port, side 2 the peer; one side acts per call, so races resolve
    task automatic tok_wr(input logic [1:0] s, input logic [2:0] i, input logic v);
        if (!v) begin
            if (own[i] == 2'h0) own[i] = s;
            else if (own[i] != s) pend[i] = pend[i] | s;
        end else if (own[i] == s) begin
            own[i] = pend[i] & ~s;
            pend[i] = 2'h0;
        end else pend[i] = pend[i] & ~s;
    endtask : tok_wr

    // Negedge keeps clear of the host's registered pin updates
    always @(negedge ref_clk) begin
        last <= dq_i;
        rd_q <= rd;
        if (rd && !rd_q) begin
            if (!pins.port_select_n) rval <= mem.exists(pins.addr) ? mem[pins.addr] : 18'h0;
            else rval <= {18{own[pins.addr[2:0]] != 2'h1}};
        end
        // A losing port's write is dropped while busy stands
        if (!pins.read_write_n && !pins.port_select_n && !busy) mem[pins.addr] = pins.dq_o;
        if (!pins.read_write_n && !pins.port_select_n && pins.addr == 16'hffff && !busy)
            peer_flag <= 1'b1;
        if (!pins.read_write_n && !pins.token_latch_select_n)
            tok_wr(2'h1, pins.addr[2:0], pins.dq_o[0]);
        if (rd && !pins.port_select_n && pins.addr == 16'hfffe && !busy) flag <= 1'b0;
        if (peer_msg) flag <= 1'b1;
        if (peer_tok) tok_wr(2'h2, peer_idx, peer_val);
    end
    // Released bus shows a changing pattern, never the last value
    assign dq_i = rd ? rval : ~last;
    assign busy_n_i = !busy;
    assign message_flag_n_i = !flag;
endmodule : dpms_dev_model
`default_nettype wire

// ### bench/dpms_host_chk.sv
// Property checker on the host controller ports
`default_nettype none
module dpms_host_chk (
    input wire logic                        ref_clk,
    input wire logic                        arst_n,
    input wire logic                        cmd_valid,
    input wire dpms_pkg::dpms_cmd_type      cmd,
    input wire logic                        cmd_ready,
    input wire logic                        rsp_valid,
    input wire logic [dpms_pkg::DATA_W-1:0] rsp_data,
    input wire logic                        rsp_busy_seen,
    input wire logic                        msg_pending,
    input wire logic                        busy_active,
    input wire dpms_pkg::dpms_pins_type     pins,
    input wire logic [dpms_pkg::DATA_W-1:0] dq_i,
    input wire logic                        busy_n_i,
    input wire logic                        message_flag_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // Pin protocol and flag tracking
    tok_csel_a: assert property (!pins.token_latch_select_n |-> pins.port_select_n)
        else $error("port select active in token access");
    tok_addr_a: assert property (!pins.token_latch_select_n |-> pins.addr[15:3] == 13'h0)
        else $error("token access with upper address bits set");
    read_oe_a: assert property (((!pins.port_select_n || !pins.token_latch_select_n)
        && !pins.dq_oe) |-> !pins.output_drive_enable_n)
        else $error("read without output enable");
    drive_clash_a: assert property (pins.dq_oe |-> pins.output_drive_enable_n)
        else $error("host drives data while device output enabled");
    busy_hold_a: assert property (($fell(pins.read_write_n) && !pins.port_select_n)
        |-> !busy_active)
        else $error("array write started under busy");
    tok_gap_a: assert property ($rose(pins.token_latch_select_n)
        |-> pins.token_latch_select_n [*3])
        else $error("token recovery gap too short");
    msg_seen_a: assert property ($fell(message_flag_n_i) |-> ##[2:4] msg_pending)
        else $error("message flag not reported");
    msg_clr_a: assert property ($rose(message_flag_n_i) |-> ##[2:4] !msg_pending)
        else $error("message flag clear not reported");
    busy_seen_a: assert property ($fell(busy_n_i) |-> ##[2:4] busy_active)
        else $error("busy not reported");
    busy_gone_a: assert property ($rose(busy_n_i) |-> ##[2:4] !busy_active)
        else $error("busy release not reported");
endmodule : dpms_host_chk
bind dpms_host dpms_host_chk dpms_host_chk_inst (.ref_clk, .arst_n, .cmd_valid, .cmd,
    .cmd_ready, .rsp_valid, .rsp_data, .rsp_busy_seen, .msg_pending, .busy_active,
    .pins, .dq_i, .busy_n_i, .message_flag_n_i);
`default_nettype wire

// ### bench/test_dpms_host.sv
// Self-checking bench: host controller against the device model
`default_nettype none
module test_dpms_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    ref_clk = 1'b0;
    logic                    arst_n = 1'b0;
    logic                    cmd_valid = 1'b0;
    dpms_pkg::dpms_cmd_type  cmd = '0;
    logic                    busy = 1'b0;
    logic                    peer_msg = 1'b0;
    logic                    peer_tok = 1'b0;
    logic [2:0]              peer_idx = 3'h0;
    logic                    peer_val = 1'b0;
    logic                    cmd_ready, rsp_valid, rsp_busy_seen, msg_pending, busy_active;
    logic [17:0]             rsp_data, dq_i;
    logic                    busy_n_i, message_flag_n_i;
    dpms_pkg::dpms_pins_type pins;
    int                      num_errors = 0;
    int                      total_checks = 0;

    dpms_host dpms_host_inst (.ref_clk, .arst_n, .cmd_valid, .cmd, .cmd_ready, .rsp_valid,
        .rsp_data, .rsp_busy_seen, .msg_pending, .busy_active, .pins, .dq_i, .busy_n_i,
        .message_flag_n_i);
    dpms_dev_model dpms_dev_model_inst (.ref_clk, .pins, .busy, .peer_msg, .peer_tok,
        .peer_idx, .peer_val, .dq_i, .busy_n_i, .message_flag_n_i);

    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic run(input dpms_pkg::dpms_op_type op, input logic [15:0] a,
                       input logic [17:0] d);
        int n;
        n = 0;
        cmd <= '{op: op, addr: a, wdata: d};
        cmd_valid <= 1'b1;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 400) check("response", 1'b0, 1'b1);
    endtask : run
    task automatic peer(input logic [2:0] i, input logic v);
        peer_idx <= i;
        peer_val <= v;
        peer_tok <= 1'b1;
        @(posedge ref_clk);
        peer_tok <= 1'b0;
    endtask : peer
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ==========================================
    // Scenarios
    task automatic t_mem;
        run(dpms_pkg::OP_WRITE, 16'h0123, 18'h2a5c3);
        run(dpms_pkg::OP_READ, 16'h0123, 18'h0);
        check("array word", rsp_data, 18'h2a5c3);
        check("busy seen", rsp_busy_seen, 1'b0);
        run(dpms_pkg::OP_WRITE, dpms_pkg::MBOX_RIGHT_ADDR, 18'h1beef);
        run(dpms_pkg::OP_READ, dpms_pkg::MBOX_RIGHT_ADDR, 18'h0);
        check("peer mailbox", rsp_data, 18'h1beef);
        check("peer flag", dpms_dev_model_inst.peer_flag, 18'h1);
        $display("test mem done");
    endtask : t_mem
    task automatic t_mbox;
        peer_msg <= 1'b1;
        @(posedge ref_clk);
        peer_msg <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("flag raised", msg_pending, 1'b1);
        run(dpms_pkg::OP_READ, dpms_pkg::MBOX_RIGHT_ADDR, 18'h0);
        check("flag after peer read", msg_pending, 1'b1);
        busy <= 1'b1;
        repeat (6) @(posedge ref_clk);
        run(dpms_pkg::OP_READ, dpms_pkg::MBOX_LEFT_ADDR, 18'h0);
        check("busy seen", rsp_busy_seen, 1'b1);
        repeat (6) @(posedge ref_clk);
        check("flag under busy", msg_pending, 1'b1);
        busy <= 1'b0;
        repeat (6) @(posedge ref_clk);
        run(dpms_pkg::OP_READ, dpms_pkg::MBOX_LEFT_ADDR, 18'h0);
        repeat (6) @(posedge ref_clk);
        check("flag cleared", msg_pending, 1'b0);
        $display("test mailbox done");
    endtask : t_mbox
    task automatic t_tok;
        for (int i = 0; i < 8; i++) begin
            run(dpms_pkg::OP_TOKEN_TAKE, 16'(i), 18'h0);
            check("take", rsp_data, 18'h0);
            run(dpms_pkg::OP_TOKEN_READ, 16'hfff8 | 16'(i), 18'h0);
            check("own", rsp_data, 18'h0);
        end
        peer(3'h5, 1'b0);
        run(dpms_pkg::OP_TOKEN_WRITE, 16'h0005, 18'h00001);
        run(dpms_pkg::OP_TOKEN_READ, 16'h0005, 18'h0);
        check("handed over", rsp_data, 18'h3ffff);
        run(dpms_pkg::OP_TOKEN_WRITE, 16'h0005, 18'h00000);
        run(dpms_pkg::OP_TOKEN_READ, 16'h0005, 18'h0);
        check("waiting", rsp_data, 18'h3ffff);
        peer(3'h5, 1'b1);
        run(dpms_pkg::OP_TOKEN_READ, 16'h0005, 18'h0);
        check("passed back", rsp_data, 18'h0);
        run(dpms_pkg::OP_TOKEN_WRITE, 16'h0005, 18'h00001);
        run(dpms_pkg::OP_TOKEN_READ, 16'h0005, 18'h0);
        check("free", rsp_data, 18'h3ffff);
        $display("test token done");
    endtask : t_tok
    task automatic t_stall;
        busy <= 1'b1;
        repeat (6) @(posedge ref_clk);
        fork
            run(dpms_pkg::OP_WRITE, 16'h0040, 18'h15a5a);
            begin
                repeat (30) @(posedge ref_clk);
                check("write held", pins.read_write_n, 18'h1);
                check("select held", pins.port_select_n, 18'h0);
                check("busy shown", busy_active, 18'h1);
                busy <= 1'b0;
            end
        join
        check("busy seen", rsp_busy_seen, 18'h1);
        run(dpms_pkg::OP_READ, 16'h0040, 18'h0);
        check("late write", rsp_data, 18'h15a5a);
        $display("test stall done");
    endtask : t_stall

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_mem();
        t_mbox();
        t_stall();
        t_tok();
        test_done();
    end
    // Whole run needs about 600 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        test_done();
    end
endmodule : test_dpms_host
`default_nettype wire
